// file: design/srp_defs.svh
// constants for the two-wire serial register port
// Operation
// - address byte LSB 1 means read, 0 means write.
// - slave address bit one follows the address select pin level.
// - start is SDA falling while SCL high, detected at any time.
// - eight bits shifted in MSB first: 7-bit address then direction.
// - matching address is acknowledged by holding SDA low on ninth pulse.
// - on mismatch release bus, idle until next start and matching address.
// - in a write, second byte is the starting register pointer.
// - pointer advances by one after each data byte written or read; the code holds it at 7'h1f after a read of the last register.
// - out-of-sequence stop returns bus machine to idle at once; start restarts address reception.
// - pointer naming a missing register gets no acknowledge, then idle.
// - reads past highest register keep returning that register's contents.
// - write past highest register is discarded, not acknowledged, then idle.
// - pointer is write-only; every other register reads and writes.
// - port and registers stay fully usable during sleep.
`ifndef SRP_DEFS_SVH
`define SRP_DEFS_SVH

// fixed address bits around the pin-selected bit; values are arbitrary
`define SRP_ADDR_HI       5'h15
`define SRP_ADDR_LO       1'b0
`define SRP_RW_READ       1'b1
`define SRP_NUM_REGS      32
`define SRP_LAST_REG      7'h1f
`define SRP_IDX_MSB       4
`define SRP_BYTE_BITS     4'h8
`define SRP_REG_RESET     8'h00
`define SRP_PTR_RESET     7'h00
`define SRP_CNT_RESET     4'h0

`endif

// file: design/srp_pkg.sv
// types shared by the serial register port
package srp_pkg;

   // one sample of the two bus lines
   typedef struct packed {
      logic scl;
      logic sda;
   } srp_line_t;

   // bus state machine, one-hot
   typedef enum logic [8:0] {
      SRP_IDLE      = 9'h001,
      SRP_ADDR      = 9'h002,
      SRP_ADDR_ACK  = 9'h004,
      SRP_PTR       = 9'h008,
      SRP_PTR_ACK   = 9'h010,
      SRP_WDATA     = 9'h020,
      SRP_WDATA_ACK = 9'h040,
      SRP_RDATA     = 9'h080,
      SRP_RACK      = 9'h100
   } srp_state_t;

endpackage

// file: design/srp_serial_port.sv
// two-wire slave port giving a host access to the control registers
`timescale 1ns/1ps
`include "srp_defs.svh"

module srp_serial_port (
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic                         sclIn,
   input  wire logic                         sdaIn,
   output wire logic                         sdaOut,
   output logic                              sdaOe,
   input  wire logic                         addressSelectPin,
   output wire logic [`SRP_NUM_REGS*8-1:0]   regBank
);

   ////////////////////////////////////////////////////////////////////////
   // declarations

   srp_pkg::srp_line_t  lineMeta;
   srp_pkg::srp_line_t  lineSync;
   srp_pkg::srp_line_t  lineLast;
   logic                pinMeta;
   logic                addressBitOne;

   srp_pkg::srp_state_t state;
   logic [3:0]          bitCnt;
   logic [7:0]          shiftReg;
   logic                readDir;
   logic                masterAck;
   logic [6:0]          regPtr;
   logic [7:0]          regs [0:`SRP_NUM_REGS-1];

   logic                sclRise;
   logic                sclFall;
   logic                startCond;
   logic                stopCond;
   logic                endOfByte;
   logic [6:0]          ownAddr;
   logic                ptrValid;
   logic                writeInRange;
   logic                ptrLoad;
   logic                regWrite;
   logic                readAdvance;
   logic [6:0]          readIdx;
   logic [7:0]          readByte;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   // the bus lines and the strap come from outside, so two flops each;
   // edge logic looks only at the second stage and its delayed copy
   always_ff @(posedge clk) begin
      if (rst) begin
         lineMeta <= '{scl: 1'b1, sda: 1'b1};
         lineSync <= '{scl: 1'b1, sda: 1'b1};
         lineLast <= '{scl: 1'b1, sda: 1'b1};
      end else begin
         lineMeta <= '{scl: sclIn, sda: sdaIn};
         lineSync <= lineMeta;
         lineLast <= lineSync;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pinMeta       <= 1'b0;
         addressBitOne <= 1'b0;
      end else begin
         pinMeta       <= addressSelectPin;
         addressBitOne <= pinMeta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus events and decisions

   assign sclRise   = lineSync.scl & ~lineLast.scl;
   assign sclFall   = ~lineSync.scl & lineLast.scl;

   // watched in every state, not only in idle
   assign startCond = lineSync.scl & lineLast.scl &
                      ~lineSync.sda & lineLast.sda;
   assign stopCond  = lineSync.scl & lineLast.scl &
                      lineSync.sda & ~lineLast.sda;

   assign endOfByte = sclFall & (bitCnt == `SRP_BYTE_BITS);

   // one address bit follows the strap so two parts can share the bus
   assign ownAddr   = {`SRP_ADDR_HI, addressBitOne, `SRP_ADDR_LO};

   // pointer top bit is ignored; only the select field is used
   assign ptrValid  = (shiftReg[6:0] <= `SRP_LAST_REG);
   assign writeInRange = (regPtr <= `SRP_LAST_REG);

   assign ptrLoad   = (state == srp_pkg::SRP_PTR) & endOfByte &
                      ptrValid;
   assign regWrite  = (state == srp_pkg::SRP_WDATA) & endOfByte &
                      writeInRange;
   assign readAdvance = (state == srp_pkg::SRP_RDATA) & endOfByte;

   // past the top the last register keeps coming back
   assign readIdx   = writeInRange ? regPtr : `SRP_LAST_REG;
   assign readByte  = regs[readIdx[`SRP_IDX_MSB:0]];

   // open drain: only ever pull low
   assign sdaOut    = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // bus state machine

   always_ff @(posedge clk) begin
      if (rst) begin
         state     <= srp_pkg::SRP_IDLE;
         bitCnt    <= `SRP_CNT_RESET;
         shiftReg  <= `SRP_REG_RESET;
         readDir   <= 1'b0;
         masterAck <= 1'b0;
         sdaOe     <= 1'b0;
      end else if (stopCond) begin
         // a stop at any point ends the transfer at once
         state <= srp_pkg::SRP_IDLE;
         sdaOe <= 1'b0;
      end else if (startCond) begin
         // repeated start also restarts address reception
         state  <= srp_pkg::SRP_ADDR;
         bitCnt <= `SRP_CNT_RESET;
         sdaOe  <= 1'b0;
      end else begin
         case (state)
            srp_pkg::SRP_IDLE: begin
               sdaOe <= 1'b0;
            end
            srp_pkg::SRP_ADDR,
            srp_pkg::SRP_PTR,
            srp_pkg::SRP_WDATA: begin
               if (sclRise && bitCnt != `SRP_BYTE_BITS) begin
                  // sampled on the high phase, msb first
                  shiftReg <= {shiftReg[6:0], lineSync.sda};
                  bitCnt   <= bitCnt + 4'h1;
               end
               if (endOfByte) begin
                  bitCnt <= `SRP_CNT_RESET;
                  if (state == srp_pkg::SRP_ADDR) begin
                     if (shiftReg[7:1] == ownAddr) begin
                        readDir <= shiftReg[0];
                        sdaOe   <= 1'b1;
                        state   <= srp_pkg::SRP_ADDR_ACK;
                     end else begin
                        state <= srp_pkg::SRP_IDLE;
                     end
                  end else if (state == srp_pkg::SRP_PTR) begin
                     if (ptrValid) begin
                        sdaOe <= 1'b1;
                        state <= srp_pkg::SRP_PTR_ACK;
                     end else begin
                        state <= srp_pkg::SRP_IDLE;
                     end
                  end else begin
                     if (writeInRange) begin
                        sdaOe <= 1'b1;
                        state <= srp_pkg::SRP_WDATA_ACK;
                     end else begin
                        state <= srp_pkg::SRP_IDLE;
                     end
                  end
               end
            end
            srp_pkg::SRP_ADDR_ACK: begin
               if (sclFall) begin
                  if (readDir == `SRP_RW_READ) begin
                     // first read byte comes from the held pointer
                     shiftReg <= readByte;
                     sdaOe    <= ~readByte[7];
                     state    <= srp_pkg::SRP_RDATA;
                  end else begin
                     sdaOe <= 1'b0;
                     state <= srp_pkg::SRP_PTR;
                  end
               end
            end
            srp_pkg::SRP_PTR_ACK,
            srp_pkg::SRP_WDATA_ACK: begin
               if (sclFall) begin
                  sdaOe <= 1'b0;
                  state <= srp_pkg::SRP_WDATA;
               end
            end
            srp_pkg::SRP_RDATA: begin
               if (sclRise && bitCnt != `SRP_BYTE_BITS) begin
                  bitCnt <= bitCnt + 4'h1;
               end
               if (sclFall) begin
                  if (bitCnt == `SRP_BYTE_BITS) begin
                     // let go so the master can answer
                     bitCnt <= `SRP_CNT_RESET;
                     sdaOe  <= 1'b0;
                     state  <= srp_pkg::SRP_RACK;
                  end else begin
                     shiftReg <= {shiftReg[6:0], 1'b0};
                     sdaOe    <= ~shiftReg[6];
                  end
               end
            end
            srp_pkg::SRP_RACK: begin
               if (sclRise) begin
                  masterAck <= ~lineSync.sda;
               end
               if (sclFall) begin
                  if (masterAck) begin
                     shiftReg <= readByte;
                     sdaOe    <= ~readByte[7];
                     state    <= srp_pkg::SRP_RDATA;
                  end else begin
                     // not-acknowledge closes the read
                     state <= srp_pkg::SRP_IDLE;
                  end
               end
            end
            default: begin
               state <= srp_pkg::SRP_IDLE;
               sdaOe <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register pointer

   // held across transfers so a later read starts where it was set;
   // it has no read path of its own
   always_ff @(posedge clk) begin
      if (rst) begin
         regPtr <= `SRP_PTR_RESET;
      end else if (ptrLoad) begin
         regPtr <= shiftReg[6:0];
      end else if (regWrite) begin
         regPtr <= regPtr + 7'h01;
      end else if (readAdvance && regPtr < `SRP_LAST_REG) begin
         // saturates so the top register repeats
         regPtr <= regPtr + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers

   // nothing here looks at a sleep bit, so access never stops in sleep
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < `SRP_NUM_REGS; i++) begin
            regs[i] <= `SRP_REG_RESET;
         end
      end else if (regWrite) begin
         regs[regPtr[`SRP_IDX_MSB:0]] <= shiftReg;
      end
   end

   generate
      for (genvar g = 0; g < `SRP_NUM_REGS; g++) begin : gBank
         assign regBank[g*8 +: 8] = regs[g];
      end
   endgenerate

endmodule // srp_serial_port

// file: dv/srp_host_model.sv
// two-wire bus master standing in for the host controller
`timescale 1ns/1ps
module srp_host_model (
   output logic    sclLine,
   output logic    sdaOe,
   input wire logic sdaWire
);
   // quarter of the 48 ns bus clock; never lands on a rising clk edge
   localparam time Q = 12ns;
   initial begin
      sclLine = 1'b1;
      sdaOe = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////
   // a stop and the start after it share one scl high, the condition edge on sda made only while scl is high
   task automatic start();
      sdaOe = 1'b0;
      #Q sclLine = 1'b1;
      #Q sdaOe = 1'b1;
      #Q sclLine = 1'b0;
   endtask
   task automatic stop();
      sdaOe = 1'b1;
      #Q sclLine = 1'b1;
      #Q sdaOe = 1'b0;
      #Q;
   endtask
   // data changes only with scl low, sampled mid-high
   task automatic bit1(input logic b, output logic r);
      sdaOe = ~b;
      #Q sclLine = 1'b1;
      #Q r = sdaWire;
      #Q sclLine = 1'b0;
      #Q;
   endtask
   task automatic put(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit1(b[i], r);
      bit1(1'b1, r);
      ack = ~r;
   endtask
   task automatic get(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit1(1'b1, r);
         d[i] = r;
      end
      bit1(last, r);
   endtask
endmodule // srp_host_model

// file: dv/srp_serial_port_chk.sv
// pin-level assertions for the serial register port
`timescale 1ns/1ps
`include "srp_defs.svh"
module srp_serial_port_chk #(parameter int W = `SRP_NUM_REGS*8) (
   input wire logic         clk,
   input wire logic         rst,
   input wire logic         sclIn,
   input wire logic         sdaIn,
   input wire logic         sdaOut,
   input wire logic         sdaOe,
   input wire logic         addressSelectPin,
   input wire logic [W-1:0] regBank
);
   logic       sclQ;
   logic       sdaQ;
   logic [5:0] bitCnt;
   logic [7:0] addrSh;
   wire        sclRise = sclIn & ~sclQ;
   wire        sclFall = ~sclIn & sclQ;
   wire        startC = sclIn & sclQ & sdaQ & ~sdaIn;
   wire        stopC = sclIn & sclQ & ~sdaQ & sdaIn;
   wire        own = addrSh[7:1] ==
                     {`SRP_ADDR_HI, addressSelectPin, `SRP_ADDR_LO};
   always_ff @(posedge clk) begin
      sclQ <= rst | sclIn;
      sdaQ <= rst | sdaIn;
   end
   // parked at the top outside transfers so idle clocking is not a byte
   always_ff @(posedge clk) begin
      if (startC) bitCnt <= 6'h00;
      else if (rst || stopC) bitCnt <= 6'h3f;
      else if (sclRise && bitCnt != 6'h3f) bitCnt <= bitCnt + 6'h01;
   end
   always_ff @(posedge clk) begin
      if (sclRise) addrSh <= {addrSh[6:0], sdaIn};
   end
   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sda_open_a: assert property (sdaOut == 1'b0)
      else $error("sda driven high");
   reset_quiet_a: assert property (disable iff (1'b0)
      rst |=> !sdaOe && regBank == '0) else $error("reset state wrong");
   addr_quiet_a: assert property (bitCnt < 6'h08 |-> !sdaOe)
      else $error("drove sda during address byte");
   addr_ack_a: assert property (sclFall && bitCnt == 6'h08 && own
      |-> ##[1:6] sdaOe) else $error("own address not acknowledged");
   foreign_quiet_a: assert property (sclFall && bitCnt == 6'h08
      && !own |=> !sdaOe [*8]) else $error("acked a foreign address");
   start_quiet_a: assert property (startC |-> ##4 !sdaOe [*4])
      else $error("sda held after start");
   stop_quiet_a: assert property (stopC |-> ##4 !sdaOe [*4])
      else $error("sda held after stop");
   bank_late_a: assert property ($changed(regBank)
      |-> bitCnt >= 6'h1a && !sclIn) else $error("early register write");
   oe_steady_a: assert property ($changed(sdaOe) |-> !sclIn)
      else $error("sda moved while scl high");
   cover property (sclFall && bitCnt == 6'h08 && own);
   cover property ($changed(regBank));
   cover property (stopC);
endmodule // srp_serial_port_chk
bind srp_serial_port srp_serial_port_chk chk_u (.clk(clk), .rst(rst),
   .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
   .addressSelectPin(addressSelectPin), .regBank(regBank));

// file: dv/serial_register_port_bench.sv
// self-checking bench for the serial register port
`timescale 1ns/1ps
`include "srp_defs.svh"
module serial_register_port_bench;
   logic                        clk = 1'b0;
   logic                        rst = 1'b1;
   logic                        addressSelectPin = 1'b0;
   logic                        sdaOe;
   logic                        hostOe;
   logic                        sclLine;
   wire logic                   sdaOut;
   wire logic                   sdaWire;
   wire logic [`SRP_NUM_REGS*8-1:0] regBank;
   int                          n_mismatch = 0;
   int                          samples_checked = 0;
   localparam logic [7:0] WR0 = {`SRP_ADDR_HI, 2'b00, 1'b0};
   localparam logic [7:0] RD0 = WR0 | 8'h01;
   // the strap sets address bit one, which is bit two of the address byte
   localparam logic [7:0] WR1 = WR0 | 8'h04;
   // pulled-up open-drain line shared by host and device
   assign sdaWire = ~((sdaOe & ~sdaOut) | hostOe);
   always #2.5 clk = ~clk;
   srp_serial_port dut_u (.clk(clk), .rst(rst), .sclIn(sclLine),
      .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .addressSelectPin(addressSelectPin), .regBank(regBank));
   srp_host_model host_u (.sclLine(sclLine), .sdaOe(hostOe),
      .sdaWire(sdaWire));
   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic send(input logic [7:0] b, input logic exp);
      logic a;
      host_u.put(b, a);
      check({7'h00, a}, {7'h00, exp});
   endtask
   task automatic fetch(input logic last, input logic [7:0] exp);
      logic [7:0] d;
      host_u.get(last, d);
      check(d, exp);
   endtask
   task automatic reg_is(input int i, input logic [7:0] exp);
      check(regBank[8*i +: 8], exp);
   endtask
   // pointer top bit always sent as zero
   task automatic point(input logic [7:0] ptr);
      host_u.start();
      send(WR0, 1'b1);
      send(ptr, 1'b1);
   endtask
   ////////////////////////////////////////////////////////////////////
   // reg 2 top bit is sleep; the port must stay usable after it
   task automatic t_group();
      logic [7:0] v[4] = '{8'h5a, 8'h3c, 8'h80, 8'h01};
      point(8'h00);
      foreach (v[i]) send(v[i], 1'b1);
      host_u.stop();
      foreach (v[i]) reg_is(i, v[i]);
      point(8'h01);
      host_u.start();
      send(RD0, 1'b1);
      fetch(1'b0, 8'h3c);
      fetch(1'b0, 8'h80);
      fetch(1'b1, 8'h01);
      host_u.stop();
      $display("t_group done");
   endtask
   task automatic t_addr();
      @(negedge clk) addressSelectPin = 1'b1;
      repeat (4) @(negedge clk);
      host_u.start();
      send(WR0, 1'b0);
      send(8'h04, 1'b0);
      host_u.stop();
      host_u.start();
      send(WR1, 1'b1);
      send(8'h04, 1'b1);
      send(8'h77, 1'b1);
      host_u.stop();
      reg_is(4, 8'h77);
      @(negedge clk) addressSelectPin = 1'b0;
      repeat (4) @(negedge clk);
      $display("t_addr done");
   endtask
   task automatic t_abort();
      logic r;
      host_u.start();
      for (int i = 7; i > 4; i--) host_u.bit1(WR0[i], r);
      host_u.stop();
      send(WR0, 1'b0);
      host_u.stop();
      point(8'h06);
      host_u.start();
      send(WR0, 1'b1);
      send(8'h07, 1'b1);
      send(8'haa, 1'b1);
      host_u.stop();
      reg_is(6, 8'h00);
      reg_is(7, 8'haa);
      $display("t_abort done");
   endtask
   task automatic t_edge();
      host_u.start();
      send(WR0, 1'b1);
      send(8'h20, 1'b0);
      send(8'h11, 1'b0);
      host_u.stop();
      point(8'h1e);
      send(8'h61, 1'b1);
      send(8'h62, 1'b1);
      send(8'h63, 1'b0);
      send(8'h64, 1'b0);
      host_u.stop();
      reg_is(31, 8'h62);
      reg_is(0, 8'h5a);
      point(8'h1e);
      host_u.start();
      send(RD0, 1'b1);
      fetch(1'b0, 8'h61);
      fetch(1'b0, 8'h62);
      fetch(1'b0, 8'h62);
      fetch(1'b1, 8'h62);
      host_u.stop();
      $display("t_edge done");
   endtask
   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      t_group();
      t_addr();
      t_abort();
      t_edge();
      close_out();
   end
   // about 40 bus bytes are sent; this allows over ten times that
   initial begin
      #200us;
      n_mismatch++;
      close_out();
   end
endmodule // serial_register_port_bench
